// ==== design/core_trim_select.sv ====
// Chooses the active trims from mode, input and calibration enable
module core_trim_select (
  input wire logic i_single,
  input wire logic i_second_input,
  input wire logic i_fgcal,
  input wire logic [5:0][7:0] i_time_trim,
  input wire logic [2:0][15:0] i_offset_trim,
  output logic [7:0] o_time_a,
  output logic [7:0] o_time_b,
  output logic [11:0] o_offset_a
);

  // Pure decode; the caller registers the result
  always_comb
  begin
    // Core A keeps its dual trim unless single mode with calibration
    o_time_a = i_time_trim[lane_trim_pkg::TT_A_DUAL];
    // Core B and offset fall back to no adjustment
    o_time_b = 8'h00;
    o_offset_a = 12'h000;
    if (i_single && i_fgcal)
    begin
      // Interleaved mode picks per sampled input
      o_time_a = i_second_input ? i_time_trim[lane_trim_pkg::TT_A_IN2]
                                : i_time_trim[lane_trim_pkg::TT_A_IN1];
      o_time_b = i_second_input ? i_time_trim[lane_trim_pkg::TT_B_IN2]
                                : i_time_trim[lane_trim_pkg::TT_B_IN1];
    end
    else if (!i_single && i_fgcal)
    begin
      o_time_b = i_time_trim[lane_trim_pkg::TT_B_DUAL];
    end
    if (i_single && !i_second_input)
    begin
      o_offset_a = i_offset_trim[lane_trim_pkg::OT_SINGLE_IN1][11:0];
    end
    else if (!i_single && i_fgcal)
    begin
      o_offset_a = i_second_input
                   ? i_offset_trim[lane_trim_pkg::OT_DUAL_IN2][11:0]
                   : i_offset_trim[lane_trim_pkg::OT_DUAL_IN1][11:0];
    end
  end

endmodule : core_trim_select

// ==== design/lane_alarm_and_core_trim_regs.sv ====
// Functional notes
// - Each lane FIFO error sets its alarm bit
// - Write one clears lane bit, zero keeps
// - Persisting error sets the bit again
// - Write one to summary clears all lanes
// - Any lane error sets summary bit five
// - Timing trims shift each core's sampling instant
// - Trims load fuse values, software may overwrite
// - Dual mode: core A uses its dual trim
// - Dual with calibration: core B dual trim
// - Single calibrated: core A trim per input
// - Single calibrated: core B trim per input
// - Dual calibrated first input: offset one
// - Dual calibrated second input: offset two
// - Single mode first input: offset three
module lane_alarm_and_core_trim_regs (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [15:0] i_lane_fifo_event,
  input wire logic [47:0] i_fuse_time_trim,
  input wire logic [35:0] i_fuse_offset_trim,
  output logic [7:0] o_time_trim_a,
  output logic [7:0] o_time_trim_b,
  output logic [11:0] o_offset_trim_a,
  output logic o_irq
);

  // Whole block state in one record
  typedef struct packed {
    lane_trim_pkg::bus_state_e bus;  // Handshake phase
    logic waitreq;                   // Registered wait request
    logic [31:0] rdata;              // Registered read data
    logic [15:0] lane_flags;         // Per-lane sticky alarms
    logic summary;                   // Summary FIFO alarm
    logic [5:0] mask;                // Alarm mask, one masks
    logic [2:0] ctrl;                // Mode, input and calibration
    logic [5:0][7:0] time_trim;      // Timing trims
    logic [2:0][15:0] off_trim;      // Offset trims, top nibble spare
    logic [7:0] out_time_a;          // Applied core A timing
    logic [7:0] out_time_b;          // Applied core B timing
    logic [11:0] out_off_a;          // Applied core A offset
    logic irq;                       // Interrupt level
  } regs_s;

  regs_s state;
  regs_s next_state;
  regs_s reset_state;

  logic [15:0] lane_evt;    // Synchronised error levels
  logic req;                // Any bus request
  logic take;               // First cycle of a request
  logic wr_fire;            // Write completes this edge
  logic [15:0] wmask;       // Byte lanes of a write
  logic [15:0] lane_clear;  // Lane bits cleared by software
  logic sum_clear;          // Summary bit cleared by software
  logic [31:0] rd_value;    // Read mux result
  logic [7:0] sel_time_a;   // Selected timing, core A
  logic [7:0] sel_time_b;   // Selected timing, core B
  logic [11:0] sel_off_a;   // Selected offset, core A

  // Lane errors come from the serial domain, so they are resynchronised
  lane_event_sync #(
    .WIDTH(lane_trim_pkg::LANES)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_lane_fifo_event),
    .o_sync(lane_evt)
  );

  // Trim choice from current settings
  core_trim_select u_select (
    .i_single(state.ctrl[lane_trim_pkg::CTRL_SINGLE_BIT]),
    .i_second_input(state.ctrl[lane_trim_pkg::CTRL_INPUT_BIT]),
    .i_fgcal(state.ctrl[lane_trim_pkg::CTRL_FGCAL_BIT]),
    .i_time_trim(state.time_trim),
    .i_offset_trim(state.off_trim),
    .o_time_a(sel_time_a),
    .o_time_b(sel_time_b),
    .o_offset_a(sel_off_a)
  );

  // Reset image; trims come from the fuse bank
  always_comb
  begin
    reset_state = '0;
    reset_state.bus = lane_trim_pkg::BUS_IDLE;
    reset_state.waitreq = 1'b1;
    reset_state.lane_flags = lane_trim_pkg::LANE_ALARM_RST;
    reset_state.summary = lane_trim_pkg::SUMMARY_ALARM_RST;
    reset_state.mask = lane_trim_pkg::ALARM_MASK_RST;
    reset_state.ctrl = lane_trim_pkg::CTRL_RST;
    reset_state.time_trim = i_fuse_time_trim;
    for (int t = 0; t < lane_trim_pkg::OFFSET_TRIMS; t++)
    begin
      // Spare top nibble starts at zero
      reset_state.off_trim[t] = {4'h0, i_fuse_offset_trim[t*12 +: 12]};
    end
  end

  // Request decode; a write lands only on the answering edge
  always_comb
  begin
    req = i_avs_read || i_avs_write;
    take = req && (state.bus == lane_trim_pkg::BUS_IDLE);
    wr_fire = i_avs_write && (state.bus == lane_trim_pkg::BUS_ACK);
    wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  end

  // Read mux; unmapped words and unused bits read zero, but offset words return all 16 bits, spare top nibble included
  always_comb
  begin
    rd_value = 32'h0000_0000;
    for (int t = 0; t < lane_trim_pkg::TIME_TRIMS; t++)
    begin
      if (i_avs_address == lane_trim_pkg::TIME_IDX[t])
      begin
        rd_value = {24'h000000, state.time_trim[t]};
      end
    end
    for (int t = 0; t < lane_trim_pkg::OFFSET_TRIMS; t++)
    begin
      if (i_avs_address == lane_trim_pkg::OFFSET_IDX[t])
      begin
        rd_value = {16'h0000, state.off_trim[t]};
      end
    end
    case (i_avs_address)
      lane_trim_pkg::ALARM_STATUS_REGISTER_IDX:
      begin
        rd_value[lane_trim_pkg::SUMMARY_FIFO_ALARM_BIT] = state.summary;
      end
      lane_trim_pkg::ALARM_MASK_IDX:
      begin
        rd_value = {26'h0000000, state.mask};
      end
      lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX:
      begin
        rd_value = {16'h0000, state.lane_flags};
      end
      lane_trim_pkg::TRIM_CTRL_IDX:
      begin
        rd_value = {29'h00000000, state.ctrl};
      end
      default:
      begin
        rd_value = rd_value;
      end
    endcase
  end

  // Software clear terms for the alarm bits
  always_comb
  begin
    lane_clear = 16'h0000;
    sum_clear = 1'b0;
    if (wr_fire && i_avs_address == lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX)
    begin
      lane_clear = i_avs_writedata[15:0] & wmask;
    end
    if (wr_fire && i_avs_address == lane_trim_pkg::ALARM_STATUS_REGISTER_IDX
        && i_avs_byteenable[0]
        && i_avs_writedata[lane_trim_pkg::SUMMARY_FIFO_ALARM_BIT])
    begin
      sum_clear = 1'b1;
      lane_clear = 16'hffff;
    end
  end

  // Next state of the whole block
  always_comb
  begin
    next_state = state;
    // One wait cycle, then a single answer cycle
    next_state.bus = take ? lane_trim_pkg::BUS_ACK : lane_trim_pkg::BUS_IDLE;
    next_state.waitreq = !take;
    if (take && i_avs_read)
    begin
      next_state.rdata = rd_value;
    end
    // Set beats clear, so an error in the clearing cycle is kept
    next_state.lane_flags = (state.lane_flags & ~lane_clear) | lane_evt;
    next_state.summary = (state.summary && !sum_clear) || (|lane_evt);
    if (wr_fire)
    begin
      // Plain read/write registers
      for (int t = 0; t < lane_trim_pkg::TIME_TRIMS; t++)
      begin
        if (i_avs_address == lane_trim_pkg::TIME_IDX[t] && i_avs_byteenable[0])
        begin
          next_state.time_trim[t] = i_avs_writedata[7:0];
        end
      end
      for (int t = 0; t < lane_trim_pkg::OFFSET_TRIMS; t++)
      begin
        if (i_avs_address == lane_trim_pkg::OFFSET_IDX[t])
        begin
          next_state.off_trim[t] = (state.off_trim[t] & ~wmask)
                                   | (i_avs_writedata[15:0] & wmask);
        end
      end
      if (i_avs_address == lane_trim_pkg::ALARM_MASK_IDX && i_avs_byteenable[0])
      begin
        next_state.mask = i_avs_writedata[5:0];
      end
      if (i_avs_address == lane_trim_pkg::TRIM_CTRL_IDX && i_avs_byteenable[0])
      begin
        next_state.ctrl = i_avs_writedata[2:0];
      end
    end
    // Applied trims refresh every cycle from the selector
    next_state.out_time_a = sel_time_a;
    next_state.out_time_b = sel_time_b;
    next_state.out_off_a = sel_off_a;
    // Interrupt follows the unmasked summary without extra lag
    next_state.irq = next_state.summary
                     && !next_state.mask[lane_trim_pkg::SUMMARY_FIFO_ALARM_BIT];
  end

  // Single state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= reset_state;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign o_avs_readdata = state.rdata;
  assign o_avs_waitrequest = state.waitreq;
  assign o_time_trim_a = state.out_time_a;
  assign o_time_trim_b = state.out_time_b;
  assign o_offset_trim_a = state.out_off_a;
  assign o_irq = state.irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Write to the lane register on its answering edge
  sequence s_lane_write;
    wr_fire && i_avs_address == lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX;
  endsequence

  // Request held through the wait cycle into the answer
  sequence s_bus_access;
    take ##1 (req && !o_avs_waitrequest);
  endsequence

  // Core A dual timing trim written on its answering edge
  sequence s_time_a_write;
    wr_fire && i_avs_address == lane_trim_pkg::CORE_A_DUAL_TIME_TRIM_IDX && i_avs_byteenable[0];
  endsequence

  a_lane_set_sticky: assert property (
    (lane_evt != 16'h0000) |=> ((state.lane_flags & $past(lane_evt)) == $past(lane_evt)))
  else $error("Lane alarm missed an error");

  a_lane_w1c_clear: assert property (
    (s_lane_write and (lane_evt == 16'h0000) and (i_avs_byteenable[1:0] == 2'b11))
    |=> state.lane_flags == ($past(state.lane_flags) & ~$past(i_avs_writedata[15:0])))
  else $error("Lane alarm write-one-clear wrong");

  a_lane_reset_again: assert property (
    (s_lane_write and (lane_evt != 16'h0000))
    |=> ((state.lane_flags & $past(lane_evt)) == $past(lane_evt)))
  else $error("Persisting lane error was lost on clear");

  a_summary_clear_all: assert property (
    (sum_clear && lane_evt == 16'h0000) |=> state.lane_flags == 16'h0000 && !state.summary)
  else $error("Summary clear did not clear lanes");

  a_summary_set: assert property (
    (|lane_evt) |=> state.summary ##0 (o_irq == !state.mask[lane_trim_pkg::SUMMARY_FIFO_ALARM_BIT]))
  else $error("Summary alarm or interrupt not raised");

  a_fuse_load: assert property (
    $past(i_rst) |-> state.time_trim == $past(i_fuse_time_trim))
  else $error("Timing trims did not load fuse values");

  a_time_a_dual: assert property (
    !state.ctrl[lane_trim_pkg::CTRL_SINGLE_BIT]
    |=> o_time_trim_a == $past(state.time_trim[lane_trim_pkg::TT_A_DUAL]))
  else $error("Core A dual timing trim not applied");

  a_time_b_dual: assert property (
    (state.ctrl == 3'h4) |=> o_time_trim_b == $past(state.time_trim[lane_trim_pkg::TT_B_DUAL]))
  else $error("Core B dual timing trim not applied");

  a_time_a_single: assert property (
    (state.ctrl == 3'h7) |=> o_time_trim_a == $past(state.time_trim[lane_trim_pkg::TT_A_IN2]))
  else $error("Core A second-input trim not applied");

  a_time_b_single: assert property (
    (state.ctrl == 3'h5) |=> o_time_trim_b == $past(state.time_trim[lane_trim_pkg::TT_B_IN1]))
  else $error("Core B first-input trim not applied");

  a_time_a_in1: assert property (
    (state.ctrl == 3'h5) |=> o_time_trim_a == $past(state.time_trim[lane_trim_pkg::TT_A_IN1]))
  else $error("Core A first-input trim not applied");

  a_time_b_in2: assert property (
    (state.ctrl == 3'h7) |=> o_time_trim_b == $past(state.time_trim[lane_trim_pkg::TT_B_IN2]))
  else $error("Core B second-input trim not applied");

  a_time_b_uncal: assert property (
    !state.ctrl[lane_trim_pkg::CTRL_FGCAL_BIT] |=> o_time_trim_b == 8'h00)
  else $error("Core B timing applied without calibration");

  a_trim_write_applied: assert property (
    (s_time_a_write and !state.ctrl[lane_trim_pkg::CTRL_SINGLE_BIT])
    |=> ##1 o_time_trim_a == $past(i_avs_writedata[7:0], 2))
  else $error("Written core A timing trim did not reach the core");

  a_offset_dual_in1: assert property (
    (state.ctrl == 3'h4)
    |=> o_offset_trim_a == $past(state.off_trim[lane_trim_pkg::OT_DUAL_IN1][11:0]))
  else $error("Dual first-input offset not applied");

  a_offset_dual_in2: assert property (
    (state.ctrl == 3'h6)
    |=> o_offset_trim_a == $past(state.off_trim[lane_trim_pkg::OT_DUAL_IN2][11:0]))
  else $error("Dual second-input offset not applied");

  a_offset_single: assert property (
    (state.ctrl[1:0] == 2'b01)
    |=> o_offset_trim_a == $past(state.off_trim[lane_trim_pkg::OT_SINGLE_IN1][11:0]))
  else $error("Single first-input offset not applied");

  a_offset_idle: assert property (
    (state.ctrl[lane_trim_pkg::CTRL_SINGLE_BIT] == 1'b0
     && state.ctrl[lane_trim_pkg::CTRL_FGCAL_BIT] == 1'b0) |=> o_offset_trim_a == 12'h000)
  else $error("Core A offset applied in uncalibrated dual mode");

  a_irq_level: assert property (
    o_irq |-> state.summary && !state.mask[lane_trim_pkg::SUMMARY_FIFO_ALARM_BIT])
  else $error("Interrupt high without an unmasked summary alarm");

  // A back-to-back request may be taken on the edge after the answer
  a_bus_one_wait: assert property (
    s_bus_access |=> o_avs_waitrequest ##1 (o_avs_waitrequest || $past(take)))
  else $error("Bus answer spacing wrong");

endmodule : lane_alarm_and_core_trim_regs

// ==== design/lane_event_sync.sv ====
// Two-stage synchroniser for the lane FIFO error levels
module lane_event_sync #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage feeds only the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s state;
  sync_s next_state;

  // Shift one stage per clock
  always_comb
  begin
    next_state = state;
    next_state.meta = i_async;
    next_state.stable = state.meta;
  end

  // Clear both stages on reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_sync = state.stable;

endmodule : lane_event_sync

// ==== design/lane_trim_pkg.sv ====
package lane_trim_pkg;

  // Bus geometry: the address is a word index, byte address is four times it
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // Trim register indices, timing trims first, array entry 0 first
  localparam logic [9:0] CORE_A_DUAL_TIME_TRIM_IDX = 10'h310;
  localparam logic [9:0] CORE_B_DUAL_TIME_TRIM_IDX = 10'h313;
  localparam logic [9:0] CORE_A_SINGLE_IN1_TIME_TRIM_IDX = 10'h314;
  localparam logic [9:0] CORE_B_SINGLE_IN1_TIME_TRIM_IDX = 10'h315;
  localparam logic [9:0] CORE_A_SINGLE_IN2_TIME_TRIM_IDX = 10'h31a;
  localparam logic [9:0] CORE_B_SINGLE_IN2_TIME_TRIM_IDX = 10'h31b;
  localparam logic [9:0] CORE_A_DUAL_IN1_OFFSET_TRIM_IDX = 10'h344;
  localparam logic [9:0] CORE_A_DUAL_IN2_OFFSET_TRIM_IDX = 10'h346;
  localparam logic [9:0] CORE_A_SINGLE_IN1_OFFSET_TRIM_IDX = 10'h348;

  // Alarm and control indices
  localparam logic [9:0] ALARM_STATUS_REGISTER_IDX = 10'h2c0;
  localparam logic [9:0] ALARM_MASK_IDX = 10'h2c2;
  localparam logic [9:0] LANE_FIFO_ALARM_FLAGS_IDX = 10'h2c4;
  localparam logic [9:0] TRIM_CTRL_IDX = 10'h300;

  // Array positions of the timing trims
  localparam int TT_A_DUAL = 0;
  localparam int TT_B_DUAL = 1;
  localparam int TT_A_IN1 = 2;
  localparam int TT_B_IN1 = 3;
  localparam int TT_A_IN2 = 4;
  localparam int TT_B_IN2 = 5;
  localparam int TIME_TRIMS = 6;

  // Array positions of the offset trims
  localparam int OT_DUAL_IN1 = 0;
  localparam int OT_DUAL_IN2 = 1;
  localparam int OT_SINGLE_IN1 = 2;
  localparam int OFFSET_TRIMS = 3;

  // Index tables, entry 0 rightmost
  localparam logic [5:0][9:0] TIME_IDX = {10'h31b, 10'h31a, 10'h315, 10'h314,
                                         10'h313, 10'h310};
  localparam logic [2:0][9:0] OFFSET_IDX = {10'h348, 10'h346, 10'h344};

  // Field widths and positions
  localparam int LANES = 16;
  localparam int TIME_W = 8;
  localparam int OFF_W = 12;
  localparam int OFF_REG_W = 16;
  localparam int MASK_W = 6;
  localparam int CTRL_W = 3;
  localparam int SUMMARY_FIFO_ALARM_BIT = 5;
  localparam int CTRL_SINGLE_BIT = 0;
  localparam int CTRL_INPUT_BIT = 1;
  localparam int CTRL_FGCAL_BIT = 2;

  // Reset values
  localparam logic [15:0] LANE_ALARM_RST = 16'hffff;
  localparam logic SUMMARY_ALARM_RST = 1'b1;
  localparam logic [5:0] ALARM_MASK_RST = 6'h3f;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Bus handshake phase
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_e;

endpackage : lane_trim_pkg

// ==== dv/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // Fuse images, entry 0 in the lowest bits
  localparam logic [47:0] FUSE_TIME = 48'h6655_4433_2211;
  localparam logic [35:0] FUSE_OFF = 36'h789_456_123;

  logic clk; // 50 MHz bench clock
  logic rst; // Synchronous reset, active high
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] lane_event; // Per-lane FIFO error levels
  logic [7:0] time_a;
  logic [7:0] time_b;
  logic [11:0] offset_a;
  logic irq;
  int err_count; // Mismatches seen
  int cmp_count; // Comparisons made

  lane_alarm_and_core_trim_regs i_lane_alarm_and_core_trim_regs (
    .i_clk(clk),
    .i_rst(rst),
    .i_avs_address(avs_address),
    .i_avs_read(avs_read),
    .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest),
    .i_lane_fifo_event(lane_event),
    .i_fuse_time_trim(FUSE_TIME),
    .i_fuse_offset_trim(FUSE_OFF),
    .o_time_trim_a(time_a),
    .o_time_trim_b(time_b),
    .o_offset_trim_a(offset_a),
    .o_irq(irq)
  );

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints counts and verdict, then stops the run
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Single comparison of a widened value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus access; waits for waitrequest low, only the watchdog ends a hang
  task bus_xfer(input logic is_wr, input logic [9:0] a, input logic [31:0] d,
                output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= is_wr;
    avs_read <= ~is_wr;
    avs_writedata <= d;
    // Pre-edge value of waitrequest is seen here, so no race with the design
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_xfer

  task wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : wr

  task rd_chk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  // Reset values, fuse loading and the unmapped hole
  task test_reset;
    for (int i = 0; i < 6; i++)
      rd_chk(lane_trim_pkg::TIME_IDX[i], {24'h0, FUSE_TIME[i*8 +: 8]});
    for (int i = 0; i < 3; i++)
      rd_chk(lane_trim_pkg::OFFSET_IDX[i], {20'h0, FUSE_OFF[i*12 +: 12]});
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'hffff);
    rd_chk(lane_trim_pkg::ALARM_STATUS_REGISTER_IDX, 32'h20);
    rd_chk(lane_trim_pkg::ALARM_MASK_IDX, 32'h3f);
    // Unmapped word: reads zero, write has no effect
    wr(10'h3ff, 32'h5a5a);
    rd_chk(10'h3ff, 32'h0);
    // Dual mode without calibration: only core A timing trim applies
    chk({24'h0, time_a}, 32'h11);
    chk({24'h0, time_b}, 32'h0);
    chk({20'h0, offset_a}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  // Lane alarm setting, clearing, persistence and the interrupt
  task test_alarm;
    wr(lane_trim_pkg::ALARM_STATUS_REGISTER_IDX, 32'h20);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h0);
    rd_chk(lane_trim_pkg::ALARM_STATUS_REGISTER_IDX, 32'h0);
    // Short error pulse on lane 3 leaves a sticky flag
    lane_event <= 16'h0008;
    repeat (5) @(posedge clk);
    lane_event <= 16'h0;
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h8);
    rd_chk(lane_trim_pkg::ALARM_STATUS_REGISTER_IDX, 32'h20);
    chk({31'h0, irq}, 32'h0);
    // Unmasking raises the interrupt while the summary is set
    wr(lane_trim_pkg::ALARM_MASK_IDX, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h0);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h8);
    wr(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h8);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h0);
    wr(lane_trim_pkg::ALARM_STATUS_REGISTER_IDX, 32'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // A clear while the error persists is overridden
    lane_event <= 16'h0200;
    repeat (5) @(posedge clk);
    wr(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h200);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h200);
    lane_event <= 16'h0;
    repeat (4) @(posedge clk);
    wr(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h200);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h0);
    // Edge lanes 0 and 15, then one summary write clears them all
    lane_event <= 16'h8001;
    repeat (5) @(posedge clk);
    lane_event <= 16'h0;
    repeat (3) @(posedge clk);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h8001);
    wr(lane_trim_pkg::ALARM_STATUS_REGISTER_IDX, 32'h20);
    rd_chk(lane_trim_pkg::LANE_FIFO_ALARM_FLAGS_IDX, 32'h0);
    $display("test_alarm done");
  endtask : test_alarm

  // Trim overwrite and selection over all eight mode codes
  task test_trim;
    logic s;
    logic sec;
    logic cal;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [11:0] eo;
    for (int i = 0; i < 6; i++)
      wr(lane_trim_pkg::TIME_IDX[i], 32'ha0 + i);
    for (int i = 0; i < 3; i++)
      wr(lane_trim_pkg::OFFSET_IDX[i], 32'h7a50 + 32'h111 * i);
    for (int i = 0; i < 6; i++)
      rd_chk(lane_trim_pkg::TIME_IDX[i], 32'ha0 + i);
    for (int i = 0; i < 3; i++)
      rd_chk(lane_trim_pkg::OFFSET_IDX[i], 32'h7a50 + 32'h111 * i);
    for (int c = 0; c < 8; c++)
    begin
      wr(lane_trim_pkg::TRIM_CTRL_IDX, c);
      repeat (2) @(posedge clk);
      s = c[0];
      sec = c[1];
      cal = c[2];
      // Core A: per-input trims only in calibrated single mode
      ea = (s && cal) ? (sec ? 8'ha4 : 8'ha2) : 8'ha0;
      // Core B: nothing applied without calibration
      eb = cal ? (s ? (sec ? 8'ha5 : 8'ha3) : 8'ha1) : 8'h0;
      // Offset: single first input needs no calibration
      eo = (s && !sec) ? 12'hc72 : ((!s && cal) ? (sec ? 12'hb61 : 12'ha50) : 12'h0);
      chk({24'h0, time_a}, {24'h0, ea});
      chk({24'h0, time_b}, {24'h0, eb});
      chk({20'h0, offset_a}, {20'h0, eo});
    end
    // Low byte lane only: the upper byte of the offset word is kept
    avs_byteenable <= 4'h1;
    wr(lane_trim_pkg::OFFSET_IDX[0], 32'h1234);
    avs_byteenable <= 4'hf;
    rd_chk(lane_trim_pkg::OFFSET_IDX[0], 32'h7a34);
    $display("test_trim done");
  endtask : test_trim

  // Main sequence: reset, then the scenarios
  initial
  begin
    err_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    lane_event = 16'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset;
    test_alarm;
    test_trim;
    end_sim;
  end

  // Watchdog: the scenarios need well under 2000 cycles
  initial
  begin
    #200000;
    err_count++;
    $display("Watchdog expired");
    end_sim;
  end

endmodule : testbench
